// ==== rtl/gauge_consts.vh ====
`ifndef GAUGE_CONSTS_VH
`define GAUGE_CONSTS_VH
// command codes
`define CMD_CONTROL        8'h00
`define CMD_LAST_STD       8'h2D
`define CMD_FLASH_CLASS    8'h3E
`define CMD_FLASH_BLOCK    8'h3F
`define CMD_FLASH_DATA     8'h40
`define CMD_FLASH_DATA_END 8'h5F
`define CMD_FLASH_CTRL     8'h61
// control subcommands
`define SUB_STATUS         16'h0000
`define SUB_SET_HIB        16'h0011
`define SUB_CLR_HIB        16'h0012
`define SUB_SEALED         16'h0020
`define SUB_UNSEAL         16'h0414
`define SUB_SLEEP_EN       16'h0013
`define SUB_TEMP_INT       16'h0015
`define SUB_TEMP_EXT       16'h0016
// user flash area
`define USER_SUBCLASS      8'h3A
`define USER_BLOCKS        3
`define USER_BLOCK_BYTES   32
`define USER_BYTES         96
// control status bit positions
`define ST_SS              13
`define ST_HIB             6
`define ST_SLEEP           4
`define ST_TEMP_INT        3
`define ST_FLASH_BUSY      2
`define ST_INIT_DONE       0
// timing
`define CLK_HZ             50000000
`define WORDPROG_MS        2
`define WORDPROG_CYC       ((`WORDPROG_MS * `CLK_HZ) / 1000)
`define INIT_CYC           16
`define IDLE_SLEEP_CYC     64
`endif

// ==== rtl/impedance_calc.v ====
`timescale 1ns/10ps
// one division step per clock; result = (ocv - loaded) * 1024 / current
module impedance_calc (
   input  wire        clk,       // clock
   input  wire        sys_rst,   // sync reset
   input  wire        start,     // pulse to begin
   input  wire [15:0] cell_i,    // cell current magnitude
   input  wire [15:0] ocv,       // open circuit voltage
   input  wire [15:0] v_load,    // loaded voltage
   output reg  [15:0] imp_r,     // impedance result
   output reg         done_r     // result valid pulse
);
   reg [25:0] num_r;
   reg [15:0] rem_r;
   reg [15:0] den_r;
   reg [4:0]  cnt_r;
   reg        busy_r;
   wire [15:0] drop    = (ocv > v_load) ? ocv - v_load : 16'h0000;
   wire [16:0] rem_sh  = {rem_r, num_r[25]};
   wire [16:0] rem_sub = rem_sh - {1'b0, den_r};
   // remainder stays below the divisor, so a set top bit can only mean a borrow
   wire        fits    = !rem_sub[16];
   wire [25:0] quo     = {num_r[24:0], fits};

   always @(posedge clk) begin
      done_r <= 1'b0;
      if (sys_rst) begin
         num_r  <= 26'h0000000;
         rem_r  <= 16'h0000;
         den_r  <= 16'h0000;
         cnt_r  <= 5'h00;
         busy_r <= 1'b0;
         imp_r  <= 16'h0000;
      end else if (start && !busy_r) begin
         num_r  <= {drop, 10'h000};
         rem_r  <= 16'h0000;
         // zero current would divide by zero; clamp to 1 so any drop of 64 or more saturates the result
         den_r  <= (cell_i == 16'h0000) ? 16'h0001 : cell_i;
         cnt_r  <= 5'h00;
         busy_r <= 1'b1;
      end else if (busy_r) begin
         // restoring division: fixed 26 clocks whatever the operands
         num_r <= quo;
         rem_r <= fits ? rem_sub[15:0] : rem_sh[15:0];
         cnt_r <= cnt_r + 5'h01;
         if (cnt_r == 5'h19) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            imp_r  <= (quo[25:16] != 10'h000) ? 16'hFFFF : quo[15:0];
         end
      end
   end
endmodule // impedance_calc

// ==== rtl/gauge_host_command_access.v ====
`timescale 1ns/10ps
`include "gauge_consts.vh"
// Function
// (RL1) commands arrive from the serial engine byte port and are executed
// (RL2) standard and extended commands read and write control and flash
// (RL3) flash reached only via the block-access command sequence
// (RL4) host supplies subclass and offset to reach a flash byte
// (RL5) 96 user flash bytes in three 32-byte blocks
// (RL6) word program takes 2 ms; further flash access held off meanwhile
// (RL7) temperature from thermistor or internal sensor, by configuration
// (RL8) four power modes: normal, sleep, hibernate, insertion check
// (RL9) modes change on events; host can force some
// (RL10) impedance computed from current, ocv and loaded voltage
// (RL11) each standard command is a low/high command code pair
// (RL12) control command followed by a two-byte subcommand
// (RL13) bus traffic ignored until power-up init completes
module gauge_host_command_access (
   input  wire        clk,          // clock
   input  wire        sys_rst,      // sync reset, high
   input  wire        wr_valid,     // byte written by host
   input  wire        wr_first,     // byte is the command code
   input  wire [7:0]  wr_data,      // written byte
   input  wire        rd_req,       // host reads next byte
   output reg  [7:0]  rd_data_r,    // read byte
   output wire        ack,          // serial engine may acknowledge
   input  wire        cell_present, // battery detected
   input  wire        load_active,  // current flowing
   input  wire [15:0] cell_i,       // measured current
   input  wire [15:0] ocv,          // open circuit voltage
   input  wire [15:0] v_cell,       // loaded cell voltage
   input  wire [15:0] temp_ext,     // thermistor reading
   input  wire [15:0] temp_int,     // internal sensor reading
   output reg  [15:0] temp_r,       // selected temperature
   output reg  [15:0] impedance_r,  // last impedance
   output reg  [3:0]  power_mode_r  // one-hot mode
);
   localparam M_NORMAL = 4'b0001;
   localparam M_SLEEP  = 4'b0010;
   localparam M_HIB    = 4'b0100;
   localparam M_INS    = 4'b1000;

   reg [7:0]  user_mem [0:`USER_BYTES-1];
   reg [7:0]  cmd_r;
   reg [7:0]  ptr_r;
   reg [15:0] sub_r;
   reg [7:0]  class_r;
   reg [1:0]  block_r;
   reg        sealed_r;
   reg        hib_req_r;
   reg        temp_int_r;
   reg        sleep_en_r;
   reg [4:0]  init_cnt_r;
   reg        init_done_r;
   reg [31:0] prog_cnt_r;
   reg [6:0]  idle_cnt_r;
   reg [3:0]  mode_nxt;
   reg        calc_go_r;
   wire [15:0] imp_val;
   wire        imp_done;
   wire        flash_busy = (prog_cnt_r != 32'h00000000);
   reg  [15:0] status_w;
   wire        data_hold;

   function in_user;                 // user subclass and block check
      input [7:0] cls;
      input [1:0] blk;
      in_user = (cls == `USER_SUBCLASS) && (blk < `USER_BLOCKS);
   endfunction

   function [6:0] faddr;
      input [1:0] blk;
      input [7:0] off;
      faddr = {blk, off[4:0]};
   endfunction

   function in_window;               // pointer inside the flash data window
      input [7:0] p;
      in_window = (p >= `CMD_FLASH_DATA) && (p <= `CMD_FLASH_DATA_END);
   endfunction

   always @* begin
      status_w                 = 16'h0000;
      status_w[`ST_SS]         = sealed_r;
      status_w[`ST_HIB]        = hib_req_r;
      status_w[`ST_SLEEP]      = power_mode_r[1];
      status_w[`ST_TEMP_INT]   = temp_int_r;
      status_w[`ST_FLASH_BUSY] = flash_busy;
      status_w[`ST_INIT_DONE]  = init_done_r;
   end

   // a data byte for the flash window is refused while a word programs
   assign data_hold = wr_valid && !wr_first && flash_busy && in_window(ptr_r); // [RL6]
   // outside normal mode a byte only wakes the gauge from sleep or hibernate; withholding the
   // acknowledge makes the host repeat it instead of losing it silently
   assign ack       = init_done_r && power_mode_r == M_NORMAL && !data_hold; // [RL13] [RL9]

   impedance_calc u_imp (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (calc_go_r),
      .cell_i  (cell_i),
      .ocv     (ocv),
      .v_load  (v_cell),
      .imp_r   (imp_val),
      .done_r  (imp_done)
   );

   always @(posedge clk) begin
      if (sys_rst) begin
         init_cnt_r  <= 5'h00;
         init_done_r <= 1'b0;
      end else if (!init_done_r) begin
         init_cnt_r  <= init_cnt_r + 5'h01;
         if (init_cnt_r == `INIT_CYC - 1)
            init_done_r <= 1'b1; // [RL13]
      end
   end

   // byte port: command code then data bytes, pointer auto-increments
   always @(posedge clk) begin
      if (sys_rst) begin
         cmd_r      <= 8'h00;
         ptr_r      <= 8'h00;
         sub_r      <= `SUB_STATUS;
         class_r    <= 8'h00;
         block_r    <= 2'b00;
         sealed_r   <= 1'b0;
         hib_req_r  <= 1'b0;
         temp_int_r <= 1'b0;
         sleep_en_r <= 1'b0;
         prog_cnt_r <= 32'h00000000;
         rd_data_r  <= 8'h00;
      end else begin
         if (flash_busy)
            prog_cnt_r <= prog_cnt_r - 32'h00000001; // [RL6]
         if (power_mode_r == M_NORMAL && wr_valid && ack) begin // [RL1]
            if (wr_first) begin
               cmd_r <= wr_data;
               ptr_r <= wr_data;
            end else begin
               ptr_r <= ptr_r + 8'h01;
               if (ptr_r == `CMD_CONTROL)
                  sub_r[7:0] <= wr_data; // [RL12]
               else if (ptr_r == `CMD_CONTROL + 8'h01) begin
                  sub_r[15:8] <= wr_data; // [RL11]
                  case ({wr_data, sub_r[7:0]}) // [RL12]
                     `SUB_SET_HIB:  hib_req_r  <= 1'b1; // [RL9]
                     `SUB_CLR_HIB:  hib_req_r  <= 1'b0;
                     `SUB_SEALED:   sealed_r   <= 1'b1; // [RL3]
                     `SUB_UNSEAL:   sealed_r   <= 1'b0;
                     `SUB_SLEEP_EN: sleep_en_r <= 1'b1;
                     `SUB_TEMP_INT: if (!sealed_r) temp_int_r <= 1'b1; // [RL7]
                     `SUB_TEMP_EXT: if (!sealed_r) temp_int_r <= 1'b0;
                     default:       sleep_en_r <= sleep_en_r;
                  endcase
               end else if (ptr_r == `CMD_FLASH_CLASS)
                  class_r <= wr_data; // [RL4]
               else if (ptr_r == `CMD_FLASH_BLOCK)
                  block_r <= wr_data[1:0]; // [RL4]
               else if (in_window(ptr_r) && in_user(class_r, block_r)) begin // [RL3] [RL5]
                  user_mem[faddr(block_r, ptr_r - `CMD_FLASH_DATA)] <= wr_data;
                  prog_cnt_r <= `WORDPROG_CYC; // [RL6]
               end
            end
         end
         if (power_mode_r == M_NORMAL && rd_req && init_done_r) begin // [RL2]
            ptr_r <= ptr_r + 8'h01;
            if (ptr_r == `CMD_CONTROL)
               rd_data_r <= (sub_r == `SUB_STATUS) ? status_w[7:0] : 8'h00;
            else if (ptr_r == `CMD_CONTROL + 8'h01)
               rd_data_r <= (sub_r == `SUB_STATUS) ? status_w[15:8] : 8'h00;
            else if (ptr_r == 8'h06)
               rd_data_r <= temp_r[7:0]; // [RL11]
            else if (ptr_r == 8'h07)
               rd_data_r <= temp_r[15:8];
            else if (ptr_r == 8'h08)
               rd_data_r <= v_cell[7:0];
            else if (ptr_r == 8'h09)
               rd_data_r <= v_cell[15:8];
            // a word still programming reads as zero rather than stale data
            else if (in_window(ptr_r) && in_user(class_r, block_r) && !flash_busy) // [RL5] [RL6]
               rd_data_r <= user_mem[faddr(block_r, ptr_r - `CMD_FLASH_DATA)];
            else
               rd_data_r <= 8'h00; // [RL3]
         end
      end
   end

   // power mode sequencing
   always @* begin
      mode_nxt = power_mode_r;
      // losing the cell outranks every other event in normal and sleep; hibernate does not check it
      case (power_mode_r)
         M_NORMAL: if (!cell_present) mode_nxt = M_INS; // [RL9]
                   else if (hib_req_r && !load_active) mode_nxt = M_HIB;
                   else if (sleep_en_r && idle_cnt_r == `IDLE_SLEEP_CYC) mode_nxt = M_SLEEP;
         M_SLEEP:  if (!cell_present) mode_nxt = M_INS;
                   else if (load_active || wr_valid || rd_req) mode_nxt = M_NORMAL;
         M_HIB:    if (wr_valid || rd_req || !hib_req_r) mode_nxt = M_NORMAL;
         M_INS:    if (cell_present) mode_nxt = M_NORMAL;
         default:  mode_nxt = M_NORMAL;
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         power_mode_r <= M_NORMAL;
         idle_cnt_r   <= 7'h00;
         temp_r       <= 16'h0000;
         impedance_r  <= 16'h0000;
         calc_go_r    <= 1'b0;
      end else begin
         power_mode_r <= mode_nxt; // [RL8] [RL9]
         if (load_active || wr_valid || rd_req || power_mode_r != M_NORMAL)
            idle_cnt_r <= 7'h00;
         else if (idle_cnt_r != `IDLE_SLEEP_CYC)
            idle_cnt_r <= idle_cnt_r + 7'h01;
         temp_r    <= temp_int_r ? temp_int : temp_ext; // [RL7]
         // only with a cell and a load can the loaded drop be measured
         calc_go_r <= cell_present && load_active && power_mode_r == M_NORMAL; // [RL10]
         if (imp_done)
            impedance_r <= imp_val; // [RL10]
      end
   end
endmodule // gauge_host_command_access

// ==== test/host_model.sv ====
`timescale 1ns/10ps
module host_model (
   input  wire       clk,       // clock
   input  wire       ack,       // byte taken
   input  wire [7:0] rd_data_r, // read byte
   output reg        wr_valid,  // byte strobe
   output reg        wr_first,  // code flag
   output reg  [7:0] wr_data,   // byte
   output reg        rd_req     // read strobe
);
   integer n_lost = 0;
   initial {wr_valid, wr_first, wr_data, rd_req} = 11'h000;
   // strobe held until ack is seen at a rising edge or lim rising edges pass
   task put(input f, input [7:0] d, input integer lim, output ok);
      integer i;
      begin
         ok = 0;
         @(negedge clk);
         {wr_valid, wr_first, wr_data} = {1'b1, f, d};
         for (i = 0; i < lim && !ok; i = i + 1) begin
            @(posedge clk);
            ok = ack;
         end
         @(negedge clk);
         {wr_valid, wr_first} = 2'h0;
      end
   endtask
   task wr_b(input [7:0] c, input [7:0] d);
      reg a, b;
      begin
         put(1'b1, c, 50, a);
         put(1'b0, d, 50, b);
         n_lost = n_lost + !(a && b);
      end
   endtask
   task wr_word(input [7:0] c, input [15:0] w);
      reg a;
      begin
         wr_b(c, w[7:0]);
         put(1'b0, w[15:8], 50, a);
         n_lost = n_lost + !a;
      end
   endtask
   task pulse_rd;
      begin
         @(negedge clk);
         rd_req = 1'b1;
         @(negedge clk);
         rd_req = 1'b0;
      end
   endtask
   task rd_word(input [7:0] c, output [15:0] w);
      reg a;
      begin
         put(1'b1, c, 50, a);
         n_lost = n_lost + !a;
         pulse_rd;
         w[7:0] = rd_data_r;
         pulse_rd;
         w[15:8] = rd_data_r;
      end
   endtask
endmodule // host_model

// ==== test/gauge_chk.sv ====
`timescale 1ns/10ps
module gauge_chk (
   input wire        clk,          // clock
   input wire        sys_rst,      // reset
   input wire        wr_valid,     // byte strobe
   input wire        rd_req,       // read strobe
   input wire [7:0]  rd_data_r,    // read byte
   input wire        ack,          // byte taken
   input wire        cell_present, // cell in
   input wire [15:0] temp_ext,     // thermistor
   input wire [15:0] temp_int,     // internal
   input wire [15:0] temp_r,       // chosen
   input wire [15:0] impedance_r,  // impedance
   input wire [3:0]  power_mode_r  // mode
);
   reg [4:0] up_r;
   reg [5:0] gone_r;
   always @(posedge clk) begin
      up_r <= sys_rst ? 5'h00 : up_r + {4'h0, up_r != 5'h1F};
      gone_r <= (sys_rst || cell_present) ? 6'h00 : gone_r + {5'h00, gone_r != 6'h3F};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence byte_in_sleep;
      power_mode_r == 4'h2 && wr_valid && cell_present;
   endsequence
   reset_state_a: assert property (disable iff (1'b0) sys_rst |=> power_mode_r == 4'h1 && !ack)
      else $error("bad state after reset");
   init_quiet_a: assert property (up_r < 5'h10 |-> !ack)
      else $error("ack before init");
   init_ready_a: assert property (up_r == 5'h10 && power_mode_r == 4'h1 |-> ack)
      else $error("no ack after init");
   early_read_a: assert property (up_r < 5'h10 && rd_req |=> $stable(rd_data_r))
      else $error("read answered before init");
   mode_onehot_a: assert property ($onehot(power_mode_r))
      else $error("mode not one-hot");
   temp_pick_a: assert property (power_mode_r == 4'h1 ##1 1'b1 |->
      temp_r == $past(temp_ext) || temp_r == $past(temp_int))
      else $error("temperature source wrong");
   rd_hold_a: assert property (!$past(rd_req) && !$past(sys_rst) |-> $stable(rd_data_r))
      else $error("read byte changed unasked");
   imp_hold_a: assert property (gone_r > 6'h2F |-> $stable(impedance_r))
      else $error("impedance moved without cell");
   sleep_wake_a: assert property (byte_in_sleep |-> ##[1:4] power_mode_r == 4'h1)
      else $error("no wake on byte");
endmodule // gauge_chk
bind gauge_host_command_access gauge_chk i_chk (.clk(clk), .sys_rst(sys_rst),
   .wr_valid(wr_valid), .rd_req(rd_req), .rd_data_r(rd_data_r), .ack(ack),
   .cell_present(cell_present), .temp_ext(temp_ext), .temp_int(temp_int),
   .temp_r(temp_r), .impedance_r(impedance_r), .power_mode_r(power_mode_r));

// ==== test/gauge_host_command_access_bench.sv ====
`timescale 1ns/10ps
module gauge_host_command_access_bench;
   reg         clk = 0;
   reg         sys_rst = 1;
   reg         cell_present = 1;
   reg         load_active = 1;
   reg  [15:0] temp_ext = 16'h0BB8;
   reg  [15:0] temp_int = 16'h0C1C;
   reg  [15:0] cell_i = 16'h0100;
   reg  [15:0] ocv = 16'h1000;
   reg  [15:0] v_cell = 16'h0E10;
   wire        wr_valid, wr_first, rd_req, ack;
   wire [7:0]  wr_data, rd_data_r;
   wire [15:0] temp_r, impedance_r;
   wire [3:0]  power_mode_r;
   reg  [63:0] rows [0:8];
   reg  [15:0] v;
   reg         ok;
   integer     n_fail = 0, n_tests = 0, i;
   always #10 clk = ~clk;
   gauge_host_command_access i_dut (.clk(clk), .sys_rst(sys_rst), .wr_valid(wr_valid),
      .wr_first(wr_first), .wr_data(wr_data), .rd_req(rd_req), .rd_data_r(rd_data_r),
      .ack(ack), .cell_present(cell_present), .load_active(load_active),
      .cell_i(cell_i), .ocv(ocv), .v_cell(v_cell), .temp_ext(temp_ext),
      .temp_int(temp_int), .temp_r(temp_r), .impedance_r(impedance_r),
      .power_mode_r(power_mode_r));
   host_model i_host (.clk(clk), .ack(ack), .rd_data_r(rd_data_r), .wr_valid(wr_valid),
      .wr_first(wr_first), .wr_data(wr_data), .rd_req(rd_req));
   task conclude;
      begin
         if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task cmp16(input [15:0] got, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wait_mode(input [3:0] m);
      for (i = 0; i < 300 && power_mode_r !== m; i = i + 1) @(negedge clk);
   endtask
   task stat;
      begin
         i_host.wr_word(8'h00, 16'h0000);
         i_host.rd_word(8'h00, v);
      end
   endtask
   // subcommand, read code, mask, expected
   initial rows = '{64'h0011_0000_0040_0040, 64'h0012_0000_0040_0000,
      64'h0016_0006_FFFF_0BB8, 64'h0015_0006_FFFF_0C1C,
      64'h0015_0000_0009_0009, 64'h0020_0000_2000_2000,
      64'h0016_0006_FFFF_0C1C, 64'h0414_0000_2000_0000,
      64'h0000_0008_FFFF_0E10};
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk) sys_rst = 0;
      cmp16({11'h000, ack, power_mode_r}, 16'h0001);
      i_host.pulse_rd;
      repeat (20) @(negedge clk);
      for (i = 0; i < 9; i = i + 1) begin
         i_host.wr_word(8'h00, rows[i][63:48]);
         if (rows[i][39:32] == 8'h00)
            i_host.wr_word(8'h00, 16'h0000);
         i_host.rd_word(rows[i][39:32], v);
         cmp16(v & rows[i][31:16], rows[i][15:0]);
      end
      cmp16(temp_r, 16'h0C1C);
      i_host.wr_b(8'h3E, 8'h50);
      i_host.wr_b(8'h3F, 8'h00);
      i_host.wr_b(8'h40, 8'h5A);
      stat;
      cmp16(v & 16'h0004, 16'h0000);
      i_host.wr_b(8'h3E, 8'h3A);
      i_host.wr_b(8'h3F, 8'h02);
      i_host.wr_b(8'h40, 8'hA5);
      stat;
      cmp16(v & 16'h0004, 16'h0004);
      i_host.put(1'b1, 8'h41, 10, ok);
      i_host.put(1'b0, 8'h33, 10, ok);
      cmp16({15'h0000, ok}, 16'h0000);
      i_host.rd_word(8'h40, v);
      cmp16(v, 16'h0000);
      cmp16(i_host.n_lost[15:0], 16'h0000);
      for (i = 0; i < 5000 && impedance_r !== 16'h07C0; i = i + 1) @(negedge clk);
      cmp16(impedance_r, 16'h07C0);
      cell_i = 16'h0200;
      for (i = 0; i < 5000 && impedance_r !== 16'h03E0; i = i + 1) @(negedge clk);
      cmp16(impedance_r, 16'h03E0);
      load_active = 0;
      i_host.wr_word(8'h00, 16'h0013);
      wait_mode(4'h2);
      cmp16({12'h000, power_mode_r}, 16'h0002);
      i_host.put(1'b1, 8'h08, 10, ok);
      cmp16({15'h0000, ok}, 16'h0001);
      wait_mode(4'h1);
      cmp16({12'h000, power_mode_r}, 16'h0001);
      i_host.wr_word(8'h00, 16'h0011);
      wait_mode(4'h4);
      cmp16({12'h000, power_mode_r}, 16'h0004);
      i_host.wr_word(8'h00, 16'h0012);
      wait_mode(4'h1);
      cmp16({12'h000, power_mode_r}, 16'h0001);
      cmp16(i_host.n_lost[15:0], 16'h0000);
      cell_present = 0;
      wait_mode(4'h8);
      cmp16({12'h000, power_mode_r}, 16'h0008);
      repeat (60) @(negedge clk);
      conclude;
   end
endmodule // gauge_host_command_access_bench
